// File: logic/pds_pkg.sv
package pds_pkg;
   localparam int CLK_MHZ = 125;
   localparam int US_W = 16;
   localparam int ADR_W = 8;

   typedef logic [31:0] pds_word_t;
   typedef logic [US_W-1:0] pds_us_t;
   typedef logic [ADR_W-1:0] pds_adr_t;
   typedef logic [3:0] pds_cnt4_t;
   typedef logic [1:0] pds_code_t;

   typedef enum logic [6:0] {
      PDS_OFF = 7'h01,
      PDS_RUN = 7'h02,
      PDS_SEQ = 7'h04,
      PDS_GRP = 7'h08,
      PDS_FAIL = 7'h10,
      PDS_POST = 7'h20,
      PDS_STBY = 7'h40
   } pds_state_t;

   localparam pds_adr_t OFF_CTRL = 8'h00;
   localparam pds_adr_t OFF_STATUS = 8'h04;
   localparam pds_adr_t OFF_MASK = 8'h08;
   localparam pds_adr_t OFF_LIMIT = 8'h0c;
   localparam pds_adr_t OFF_GAP = 8'h10;
   localparam pds_adr_t OFF_STBY = 8'h14;
   localparam pds_adr_t OFF_SLOT = 8'h40;
   localparam pds_adr_t SLOT_STRIDE = 8'h04;

   localparam int CTRL_REQ = 0;
   localparam int CTRL_STYLE = 1;
   localparam int CTRL_TB_LO = 2;
   localparam int CTRL_LEAD_LO = 4;
   localparam int STAT_SD = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_REQ = 2;
   localparam int STAT_ST_LO = 8;
   localparam int STAT_RAIL_LO = 16;
   localparam int LIM_FLT_LO = 0;
   localparam int LIM_DOG_LO = 8;
   localparam int SLOT_GRP_LO = 8;

   localparam logic [7:0] SLOT_EXCL = 8'h00;
   localparam pds_cnt4_t LIMIT_OFF = 4'h0;
   localparam pds_code_t LEAD_NONE = 2'h0;

   localparam pds_us_t SD_TIMER_US = 16'd500;
   localparam pds_us_t TB0_US = 16'd30;
   localparam pds_us_t TB1_US = 16'd120;
   localparam pds_us_t TB2_US = 16'd250;
   localparam pds_us_t TB3_US = 16'd500;
   localparam pds_us_t GAP0_US = 16'd120;
   localparam pds_us_t GAP1_US = 16'd250;
   localparam pds_us_t GAP2_US = 16'd500;
   localparam pds_us_t GAP3_US = 16'd1000;
   localparam pds_us_t LEAD0_US = 16'd0;
   localparam pds_us_t LEAD1_US = 16'd10;
   localparam pds_us_t LEAD2_US = 16'd100;
   localparam pds_us_t LEAD3_US = 16'd500;
   localparam pds_us_t POST0_US = 16'd0;
   localparam pds_us_t POST1_US = 16'd1500;
   localparam pds_us_t POST2_US = 16'd5000;
   localparam pds_us_t POST3_US = 16'd10000;

   function automatic pds_us_t pick_us(input pds_code_t c, input pds_us_t a, input pds_us_t b,
                                       input pds_us_t d, input pds_us_t e);
      case (c)
         2'h0: pick_us = a;
         2'h1: pick_us = b;
         2'h2: pick_us = d;
         default: pick_us = e;
      endcase
   endfunction
endpackage

// File: logic/pds_timer_if.sv
`timescale 1ns/1ps
interface pds_timer_if;
   logic start;
   pds_pkg::pds_us_t count;
   logic done;
   modport ctl (output start, output count, input done);
   modport tmr (input start, input count, output done);
endinterface

// File: logic/pds_tick.sv
`timescale 1ns/1ps
module pds_tick #(
   parameter int TICK_CYC = pds_pkg::CLK_MHZ
) (
   input wire logic clk_i,
   input wire logic rst_i,
   output logic tick_o
);
   import pds_pkg::*;
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } pds_tick_st_t;
   pds_tick_st_t q, n;

   always_comb begin
      n = q;
      n.tick = (q.cnt == 16'(TICK_CYC - 1));
      n.cnt = n.tick ? '0 : q.cnt + 16'h0001;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign tick_o = q.tick;
endmodule

// File: logic/pds_timer.sv
`timescale 1ns/1ps
module pds_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   pds_timer_if.tmr tm
);
   import pds_pkg::*;
   typedef struct packed {
      pds_us_t cnt;
      logic run;
      logic done;
   } pds_tmr_st_t;
   pds_tmr_st_t q, n;

   // First tick may land early, so a delay is met to within one tick
   always_comb begin
      n = q;
      n.done = 1'b0;
      if (tm.start) begin
         n.cnt = tm.count;
         n.run = (tm.count != '0);
         n.done = (tm.count == '0);
      end else if (q.run && tick_i) begin
         n.cnt = q.cnt - 16'h0001;
         if (q.cnt == 16'h0001) begin
            n.run = 1'b0;
            n.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign tm.done = q.done;
endmodule

// File: logic/pds_sequencer.sv
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
module pds_sequencer #(
   parameter int NCH = 13,
   parameter int PG_IDX = 11,
   parameter int HR_IDX = 12,
   parameter int TICK_CYC = pds_pkg::CLK_MHZ,
   parameter pds_pkg::pds_us_t LONG_PRESS_US = 16'd2000
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire pds_pkg::pds_adr_t wb_adr_i,
   input wire pds_pkg::pds_word_t wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output pds_pkg::pds_word_t wb_dat_o,
   output logic wb_ack_o,
   input wire logic power_on_pin_i,
   input wire logic power_pin_behaviour_cfg_i,
   input wire logic standby_req_i,
   input wire logic fault_timer_expired_i,
   input wire pds_pkg::pds_cnt4_t global_fault_count_i,
   input wire pds_pkg::pds_cnt4_t dog_fail_count_i,
   input wire logic junction_temp_over_i,
   input wire pds_pkg::pds_code_t slot_time_base_fuse_i,
   input wire logic [NCH*8-1:0] slot_code_fuse_i,
   input wire pds_pkg::pds_code_t post_shutdown_delay_fuse_i,
   output logic [NCH-1:0] rail_en_o,
   output logic power_good_out_o,
   output logic host_reset_out_o,
   output logic irq_out_n_o
);
   import pds_pkg::*;

   typedef struct packed {
      pds_state_t st;
      logic [NCH-1:0] rail_en;
      logic [NCH-1:0] tgt;
      logic [NCH-1:0] sv;
      logic [NCH-1:0] stby_mask;
      logic [NCH*8-1:0] slot;
      logic [NCH*2-1:0] grp;
      logic [7:0] gap;
      pds_code_t tbase;
      pds_code_t lead;
      pds_code_t mask;
      pds_code_t cg;
      pds_cnt4_t flim;
      pds_cnt4_t dlim;
      logic style;
      logic sd_req;
      logic sd_flag;
      pds_us_t sd_cnt;
      logic done;
      logic pin_q;
      logic pr_arm;
      pds_us_t pr_cnt;
      logic temp_q;
      logic hard;
      logic stby;
      logic wt;
      logic first;
      logic lp;
      logic ld;
      logic ack;
      pds_word_t dat;
      logic irqn;
   } pds_seq_st_t;

   pds_seq_st_t q, n;
   logic tick_w;
   pds_timer_if tm ();

   pds_tick #(.TICK_CYC(TICK_CYC)) u_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_o(tick_w)
   );

   pds_timer u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick_w),
      .tm(tm)
   );

   function automatic logic [NCH-1:0] slot_match(input logic [NCH-1:0] m,
                                                 input logic [NCH*8-1:0] s, input logic [7:0] v);
      slot_match = '0;
      for (int i = 0; i < NCH; i++) begin
         slot_match[i] = m[i] && (s[i*8 +: 8] == v);
      end
   endfunction

   function automatic logic [7:0] top_slot(input logic [NCH-1:0] m, input logic [NCH*8-1:0] s);
      top_slot = SLOT_EXCL;
      for (int i = 0; i < NCH; i++) begin
         if (m[i] && (s[i*8 +: 8] > top_slot)) begin
            top_slot = s[i*8 +: 8];
         end
      end
   endfunction

   function automatic logic [NCH-1:0] grp_match(input logic [NCH-1:0] m,
                                                input logic [NCH*2-1:0] g, input pds_code_t c);
      grp_match = '0;
      for (int i = 0; i < NCH; i++) begin
         grp_match[i] = m[i] && (g[i*2 +: 2] == c);
      end
   endfunction

   // Lowest code is the lowest-hierarchy group (code 00 is group 4)
   function automatic pds_code_t low_grp(input logic [NCH-1:0] m, input logic [NCH*2-1:0] g);
      low_grp = 2'h3;
      for (int c = 3; c >= 0; c--) begin
         if (|grp_match(m, g, 2'(c))) begin
            low_grp = 2'(c);
         end
      end
   endfunction

   function automatic pds_word_t merge(input pds_word_t old, input pds_word_t nw,
                                       input pds_word_t wm);
      merge = (old & ~wm) | (nw & wm);
   endfunction

   function automatic pds_adr_t slot_adr(input int i);
      slot_adr = OFF_SLOT + pds_adr_t'(i) * SLOT_STRIDE;
   endfunction

   always_comb begin
      logic [NCH-1:0] off;
      logic [NCH-1:0] rem;
      logic [NCH-1:0] gm;
      logic [NCH-1:0] used;
      pds_code_t c;
      pds_word_t wm;
      pds_word_t wv;
      pds_word_t img;
      pds_word_t ctrl_img;
      pds_word_t stat_img;
      logic wr;
      logic clr_sd;
      logic clr_done;
      logic step;
      logic fin;
      logic press_ev;
      logic sd_ev;
      logic pin_ev;
      logic hard;
      logic ev;
      off = '0;
      rem = '0;
      gm = '0;
      used = '0;
      c = '0;
      img = '0;
      clr_sd = 1'b0;
      clr_done = 1'b0;
      fin = 1'b0;
      wm = '0;
      wv = '0;
      wr = 1'b0;
      step = 1'b0;
      press_ev = 1'b0;
      sd_ev = 1'b0;
      pin_ev = 1'b0;
      hard = 1'b0;
      ev = 1'b0;
      n = q;
      tm.start = 1'b0;
      tm.count = '0;
      n.pin_q = power_on_pin_i;
      n.temp_q = junction_temp_over_i;

      ctrl_img = '0;
      ctrl_img[CTRL_REQ] = q.sd_req;
      ctrl_img[CTRL_STYLE] = q.style;
      ctrl_img[CTRL_TB_LO +: 2] = q.tbase;
      ctrl_img[CTRL_LEAD_LO +: 2] = q.lead;
      stat_img = '0;
      stat_img[STAT_SD] = q.sd_flag;
      stat_img[STAT_DONE] = q.done;
      stat_img[STAT_REQ] = q.sd_req;
      stat_img[STAT_ST_LO +: 7] = q.st;
      stat_img[STAT_RAIL_LO +: NCH] = q.rail_en;

      // Single-cycle slave: ack one cycle after the strobe, then drop
      wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      wv = wb_dat_i & wm;
      wr = wb_cyc_i && wb_stb_i && wb_we_i && q.ack;
      n.ack = wb_cyc_i && wb_stb_i && !q.ack;
      n.dat = '0;
      if (wb_cyc_i && wb_stb_i && !q.ack && !wb_we_i) begin
         case (wb_adr_i)
            OFF_CTRL: n.dat = ctrl_img;
            OFF_STATUS: n.dat = stat_img;
            OFF_MASK: n.dat = pds_word_t'(q.mask);
            OFF_LIMIT: n.dat = (pds_word_t'(q.dlim) << LIM_DOG_LO) | pds_word_t'(q.flim);
            OFF_GAP: n.dat = pds_word_t'(q.gap);
            OFF_STBY: n.dat = pds_word_t'(q.stby_mask);
            default: begin
               for (int i = 0; i < NCH; i++) begin
                  if (wb_adr_i == slot_adr(i)) begin
                     n.dat = (pds_word_t'(q.grp[i*2 +: 2]) << SLOT_GRP_LO)
                           | pds_word_t'(q.slot[i*8 +: 8]);
                  end
               end
            end
         endcase
      end
      if (wr) begin
         case (wb_adr_i)
            OFF_CTRL: begin
               img = merge(ctrl_img, wb_dat_i, wm);
               n.style = img[CTRL_STYLE];
               n.tbase = img[CTRL_TB_LO +: 2];
               n.lead = img[CTRL_LEAD_LO +: 2];
               if (wv[CTRL_REQ] && !q.sd_req && (q.st == PDS_RUN)) begin
                  n.sd_req = 1'b1;
                  n.sd_flag = 1'b1;
                  n.sd_cnt = '0;
               end
            end
            OFF_STATUS: begin
               clr_sd = wv[STAT_SD];
               clr_done = wv[STAT_DONE];
            end
            OFF_MASK: begin
               img = merge(pds_word_t'(q.mask), wb_dat_i, wm);
               n.mask = img[1:0];
            end
            OFF_LIMIT: begin
               img = merge((pds_word_t'(q.dlim) << LIM_DOG_LO) | pds_word_t'(q.flim), wb_dat_i, wm);
               n.flim = img[LIM_FLT_LO +: 4];
               n.dlim = img[LIM_DOG_LO +: 4];
            end
            OFF_GAP: begin
               img = merge(pds_word_t'(q.gap), wb_dat_i, wm);
               n.gap = img[7:0];
            end
            OFF_STBY: begin
               img = merge(pds_word_t'(q.stby_mask), wb_dat_i, wm);
               n.stby_mask = img[NCH-1:0];
            end
            default: begin
               for (int i = 0; i < NCH; i++) begin
                  if (wb_adr_i == slot_adr(i)) begin
                     img = merge((pds_word_t'(q.grp[i*2 +: 2]) << SLOT_GRP_LO)
                                 | pds_word_t'(q.slot[i*8 +: 8]), wb_dat_i, wm);
                     n.slot[i*8 +: 8] = img[7:0];
                     n.grp[i*2 +: 2] = img[SLOT_GRP_LO +: 2];
                  end
               end
            end
         endcase
      end

      // Cancel window; a clear also drops the request bit
      if (clr_sd) begin
         n.sd_flag = 1'b0;
         n.sd_req = 1'b0;
         n.sd_cnt = '0;
      end else if (q.sd_req && q.sd_flag && (q.st == PDS_RUN) && tick_w
                   && (q.sd_cnt < SD_TIMER_US)) begin
         n.sd_cnt = q.sd_cnt + 16'h0001;
      end
      if (clr_done) begin
         n.done = 1'b0;
      end
      sd_ev = q.sd_req && q.sd_flag && (q.sd_cnt >= SD_TIMER_US);

      // Pin is only watched in run and off, masked otherwise
      if (!((q.st == PDS_RUN) || (q.st == PDS_OFF)) || power_on_pin_i) begin
         n.pr_arm = 1'b0;
         n.pr_cnt = '0;
      end else if (q.pin_q) begin
         n.pr_arm = 1'b1;
         n.pr_cnt = '0;
      end else if (q.pr_arm && tick_w && (q.pr_cnt <= LONG_PRESS_US)) begin
         n.pr_cnt = q.pr_cnt + 16'h0001;
      end
      press_ev = q.pr_arm && (q.pr_cnt > LONG_PRESS_US);

      step = !q.wt || tm.done;
      case (q.st)
         PDS_RUN: begin
            pin_ev = power_pin_behaviour_cfg_i ? press_ev : !power_on_pin_i;
            hard = fault_timer_expired_i
                 || ((q.flim != LIMIT_OFF) && (global_fault_count_i == q.flim))
                 || ((q.dlim != LIMIT_OFF) && (dog_fail_count_i == q.dlim))
                 || (junction_temp_over_i && !q.temp_q);
            ev = pin_ev || sd_ev || hard;
            if (ev || (standby_req_i && |(q.rail_en & q.stby_mask))) begin
               n.st = q.style ? PDS_GRP : PDS_SEQ;
               n.stby = !ev;
               n.hard = hard;
               n.tgt = ev ? q.rail_en : (q.rail_en & q.stby_mask);
               n.sv = q.rail_en & q.stby_mask;
               n.wt = 1'b0;
               n.first = 1'b1;
               n.lp = 1'b0;
               n.pr_arm = 1'b0;
            end else if (standby_req_i) begin
               n.st = PDS_STBY;
               n.sv = '0;
               n.done = 1'b1;
            end
         end
         PDS_SEQ: begin
            if (step) begin
               off = slot_match(q.tgt, q.slot,
                                q.first ? SLOT_EXCL : top_slot(q.tgt, q.slot));
               rem = q.tgt & ~off;
               n.rail_en = q.rail_en & ~off;
               n.tgt = rem;
               n.first = 1'b0;
               if (|rem) begin
                  tm.start = 1'b1;
                  tm.count = pick_us(q.tbase, TB0_US, TB1_US, TB2_US, TB3_US);
                  n.wt = 1'b1;
               end else begin
                  fin = 1'b1;
               end
            end
         end
         PDS_GRP: begin
            if (step) begin
               if (q.lp) begin
                  c = q.cg;
                  off = grp_match(q.tgt, q.grp, c);
                  n.lp = 1'b0;
               end else begin
                  c = low_grp(q.tgt, q.grp);
                  gm = grp_match(q.tgt, q.grp, c);
                  if (gm[HR_IDX] && (q.lead != LEAD_NONE)) begin
                     off[HR_IDX] = 1'b1;
                     n.lp = 1'b1;
                     n.cg = c;
                  end else begin
                     off = gm;
                  end
               end
               rem = q.tgt & ~off;
               n.rail_en = q.rail_en & ~off;
               n.tgt = rem;
               if (n.lp) begin
                  tm.start = 1'b1;
                  tm.count = pick_us(q.lead, LEAD0_US, LEAD1_US, LEAD2_US, LEAD3_US);
                  n.wt = 1'b1;
               end else if (|rem) begin
                  tm.start = 1'b1;
                  tm.count = pick_us(q.gap[{c, 1'b0} +: 2], GAP0_US, GAP1_US,
                                     GAP2_US, GAP3_US);
                  n.wt = 1'b1;
               end else begin
                  fin = 1'b1;
               end
            end
         end
         PDS_FAIL: begin
            n.st = PDS_POST;
            tm.start = 1'b1;
            tm.count = pick_us(post_shutdown_delay_fuse_i, POST0_US, POST1_US,
                               POST2_US, POST3_US);
            n.wt = 1'b1;
         end
         PDS_POST: begin
            if (step) begin
               n.st = PDS_OFF;
               n.ld = 1'b1;
               n.wt = 1'b0;
               n.hard = 1'b0;
            end
         end
         PDS_OFF: begin
            if (q.ld) begin
               n.ld = 1'b0;
               n.tbase = slot_time_base_fuse_i;
               n.slot = slot_code_fuse_i;
            end else if (power_pin_behaviour_cfg_i ? press_ev : power_on_pin_i) begin
               for (int i = 0; i < NCH; i++) begin
                  used[i] = (q.slot[i*8 +: 8] != SLOT_EXCL);
               end
               n.st = PDS_RUN;
               n.rail_en = used;
               n.pr_arm = 1'b0;
               n.sd_req = 1'b0;
               n.sd_cnt = '0;
            end
         end
         PDS_STBY: begin
            if (!standby_req_i) begin
               n.st = PDS_RUN;
               n.rail_en = q.rail_en | q.sv;
            end
         end
         default: begin
            n.st = PDS_OFF;
         end
      endcase

      if (fin) begin
         if (q.stby) begin
            n.st = PDS_STBY;
            n.done = 1'b1;
         end else if (q.hard) begin
            n.st = PDS_FAIL;
         end else begin
            n.st = PDS_POST;
            tm.start = 1'b1;
            tm.count = pick_us(post_shutdown_delay_fuse_i, POST0_US, POST1_US,
                               POST2_US, POST3_US);
            n.wt = 1'b1;
         end
      end
      n.irqn = ~|({n.done, n.sd_flag} & ~n.mask);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.st <= PDS_OFF;
         q.ld <= 1'b1;
         q.irqn <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign wb_dat_o = q.dat;
   assign wb_ack_o = q.ack;
   assign rail_en_o = q.rail_en;
   assign power_good_out_o = q.rail_en[PG_IDX];
   assign host_reset_out_o = q.rail_en[HR_IDX];
   assign irq_out_n_o = q.irqn;
endmodule

// File: dv/pds_sequencer_sva.sv
`timescale 1ns/1ps
module pds_chk #(
   parameter int NCH = 13,
   parameter int PG_IDX = 11,
   parameter int HR_IDX = 12
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire pds_pkg::pds_adr_t wb_adr_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire pds_pkg::pds_word_t wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [NCH-1:0] rail_en_o,
   input wire logic power_good_out_o,
   input wire logic host_reset_out_o,
   input wire logic irq_out_n_o
);
   import pds_pkg::*;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ans;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   property p_ack;
      s_req |=> s_ans;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not one pulse");
   property p_idle;
      !wb_ack_o |-> wb_dat_o == '0;
   endproperty
   a_idle: assert property (p_idle) else $error("read data outside ack");
   property p_unmap;
      wb_ack_o && !wb_we_i && wb_adr_i == 8'h20 |-> wb_dat_o == '0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_stat;
      wb_ack_o && !wb_we_i && wb_adr_i == OFF_STATUS |->
         wb_dat_o[STAT_RAIL_LO +: NCH] == $past(rail_en_o);
   endproperty
   a_stat: assert property (p_stat) else $error("status rails wrong");
   property p_pg;
      power_good_out_o == rail_en_o[PG_IDX];
   endproperty
   a_pg: assert property (p_pg) else $error("power good mismatch");
   property p_hr;
      host_reset_out_o == rail_en_o[HR_IDX];
   endproperty
   a_hr: assert property (p_hr) else $error("host reset mismatch");
   property p_rst;
      disable iff (1'b0) rst_i |=> rail_en_o == '0 && irq_out_n_o && !wb_ack_o;
   endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   // Rails only rise together or fall together, never both at once
   property p_dir;
      |(rail_en_o & ~$past(rail_en_o)) |-> (~rail_en_o & $past(rail_en_o)) == '0;
   endproperty
   a_dir: assert property (p_dir) else $error("rails moved both ways");
endmodule
bind pds_sequencer pds_chk #(.NCH(NCH), .PG_IDX(PG_IDX), .HR_IDX(HR_IDX)) chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .rail_en_o(rail_en_o), .power_good_out_o(power_good_out_o),
   .host_reset_out_o(host_reset_out_o), .irq_out_n_o(irq_out_n_o));

// File: dv/pds_host.sv
`timescale 1ns/1ps
module pds_host (
   input wire logic clk_i,
   output logic pin_o,
   output logic stby_o
);
   initial pin_o = 1'b0;
   initial stby_o = 1'b0;
   // Pins move just after an edge, like a clocked host
   task automatic drive(input logic p, input logic s);
      @(posedge clk_i);
      pin_o <= p;
      stby_o <= s;
   endtask
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import pds_pkg::*;
   localparam logic [12:0] ON = 13'h1ff7;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic ack;
   logic pin;
   logic stby;
   logic irq_n;
   logic pmode = 1'b0;
   logic pg;
   logic hr;
   logic ftm = 1'b0;
   logic temp = 1'b0;
   pds_adr_t adr = '0;
   pds_word_t wd = '0;
   pds_word_t rdat;
   pds_word_t q;
   pds_cnt4_t fcnt = 4'h0;
   pds_cnt4_t dcnt = 4'h0;
   logic [103:0] fuse;
   logic [12:0] rail;
   int err_count = 0;
   int checked = 0;
   always #4 clk_i = ~clk_i;
   initial for (int i = 0; i < 13; i++) fuse[8*i +: 8] = (i == 3) ? 8'h00 : 8'(i + 1);
   pds_host host (.clk_i(clk_i), .pin_o(pin), .stby_o(stby));
   pds_sequencer #(.TICK_CYC(1), .LONG_PRESS_US(16'd5)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(4'hf),
      .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
      .power_on_pin_i(pin), .power_pin_behaviour_cfg_i(pmode), .standby_req_i(stby),
      .fault_timer_expired_i(ftm), .global_fault_count_i(fcnt), .dog_fail_count_i(dcnt),
      .junction_temp_over_i(temp), .slot_time_base_fuse_i(2'h0), .slot_code_fuse_i(fuse),
      .post_shutdown_delay_fuse_i(2'h0), .rail_en_o(rail), .power_good_out_o(pg),
      .host_reset_out_o(hr), .irq_out_n_o(irq_n));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic bus(input logic w, input pds_adr_t a, input pds_word_t d, output pds_word_t r);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wait_chg(output int n);
      logic [12:0] r0;
      r0 = rail;
      n = 0;
      while (rail === r0 && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
   endtask
   task automatic wait_rails(input logic [12:0] e);
      int n;
      n = 0;
      while (rail !== e && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(rail), 32'(e));
   endtask
   task automatic t_cancel();
      chk(32'(rail), 32'h0);
      bus(1'b0, 8'h20, 32'h0, q);
      chk(q, 32'h0);
      host.drive(1'b1, 1'b0);
      wait_rails(ON);
      bus(1'b1, OFF_CTRL, 32'h1, q);
      repeat (3) @(posedge clk_i);
      chk(32'(irq_n), 32'h0);
      bus(1'b0, OFF_STATUS, 32'h0, q);
      chk(32'(q[2]), 32'h1);
      bus(1'b1, OFF_STATUS, 32'h1, q);
      repeat (600) @(posedge clk_i);
      chk(32'(rail), 32'(ON));
      bus(1'b0, OFF_CTRL, 32'h0, q);
      chk(32'(q[0]), 32'h0);
   endtask
   task automatic t_expire();
      int n;
      bus(1'b1, OFF_CTRL, 32'h1, q);
      wait_chg(n);
      chk(32'(n > 524 && n < 541), 32'h1);
      chk(32'(rail), 32'h0ff7);
      chk(32'({hr, pg}), 32'h1);
      wait_rails(13'h0);
      bus(1'b1, OFF_STATUS, 32'h1, q);
      wait_rails(ON);
   endtask
   task automatic t_group();
      int n;
      bus(1'b1, OFF_CTRL, 32'h12, q);
      bus(1'b1, OFF_GAP, 32'h4, q);
      // Group 4 left empty so the start must skip it
      for (int i = 0; i < 13; i++) begin
         bus(1'b1, 8'(OFF_SLOT + 4 * i),
             {22'h0, (i < 6) ? 2'h1 : 2'h3, (i == 3) ? 8'h0 : 8'(i + 17)}, q);
      end
      @(posedge clk_i) temp <= 1'b1;
      wait_chg(n);
      chk(32'(n < 5), 32'h1);
      chk(32'(rail), 32'h1fc0);
      wait_chg(n);
      chk(32'(n > 246 && n < 254), 32'h1);
      chk(32'(rail), 32'h0fc0);
      chk(32'({hr, pg}), 32'h1);
      wait_chg(n);
      chk(32'(n > 8 && n < 14), 32'h1);
      chk(32'(rail), 32'h0);
      @(posedge clk_i) temp <= 1'b0;
      wait_rails(ON);
      bus(1'b0, 8'(OFF_SLOT + 48), 32'h0, q);
      chk(32'(q[7:0]), 32'hd);
   endtask
   task automatic t_pin();
      bus(1'b1, OFF_CTRL, 32'h0, q);
      host.drive(1'b0, 1'b0);
      repeat (40) @(posedge clk_i);
      host.drive(1'b1, 1'b0);
      wait_rails(13'h0);
      wait_rails(ON);
   endtask
   task automatic t_edge();
      @(posedge clk_i) pmode <= 1'b1;
      host.drive(1'b0, 1'b0);
      repeat (3) @(posedge clk_i);
      host.drive(1'b1, 1'b0);
      repeat (20) @(posedge clk_i);
      chk(32'(rail), 32'(ON));
      host.drive(1'b0, 1'b0);
      wait_rails(13'h0);
      repeat (20) @(posedge clk_i);
      chk(32'(rail), 32'h0);
      host.drive(1'b1, 1'b0);
      host.drive(1'b0, 1'b0);
      wait_rails(ON);
      host.drive(1'b1, 1'b0);
      @(posedge clk_i) pmode <= 1'b0;
   endtask
   task automatic t_fault();
      bus(1'b1, OFF_LIMIT, 32'h203, q);
      @(posedge clk_i) fcnt <= 4'h2;
      repeat (50) @(posedge clk_i);
      chk(32'(rail), 32'(ON));
      @(posedge clk_i) fcnt <= 4'h3;
      @(posedge clk_i) fcnt <= 4'h0;
      wait_rails(13'h0);
      wait_rails(ON);
      @(posedge clk_i) dcnt <= 4'h2;
      @(posedge clk_i) dcnt <= 4'h0;
      wait_rails(13'h0);
      wait_rails(ON);
      @(posedge clk_i) ftm <= 1'b1;
      @(posedge clk_i) ftm <= 1'b0;
      wait_rails(13'h0);
      wait_rails(ON);
   endtask
   task automatic t_stby();
      bus(1'b1, OFF_STBY, 32'h0, q);
      host.drive(1'b1, 1'b1);
      repeat (5) @(posedge clk_i);
      chk(32'(irq_n), 32'h0);
      chk(32'(rail), 32'(ON));
      bus(1'b1, OFF_STATUS, 32'h2, q);
      host.drive(1'b1, 1'b0);
      bus(1'b1, OFF_STBY, 32'h1, q);
      host.drive(1'b1, 1'b1);
      wait_rails(ON & 13'h1ffe);
      host.drive(1'b1, 1'b0);
      wait_rails(ON);
   endtask
   task automatic close_out();
      $display("Mismatches %0d of %0d checks", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_cancel();
      t_expire();
      t_group();
      t_pin();
      t_edge();
      t_fault();
      t_stby();
      close_out();
   end
   // Tests need about 4k cycles; a hang stops well past that
   initial begin
      repeat (40000) @(posedge clk_i);
      err_count++;
      close_out();
   end
endmodule
